// ===== rfia_params.svh
// rfia_params.svh: op-codes, field positions, reset values and sizes for the event pin block
// assumes nothing; definitions only
`ifndef RFIA_PARAMS_SVH
`define RFIA_PARAMS_SVH

`define RFIA_OP_ASSIGN_WR    8'h34
`define RFIA_OP_ASSIGN_RD    8'hD0
`define RFIA_ASSIGN_RESET    8'h00
`define RFIA_RX2_PULSE_HI    7
`define RFIA_RX2_PULSE_LO    6
`define RFIA_RX2_LEVEL_HI    5
`define RFIA_RX2_LEVEL_LO    4
`define RFIA_RX1_PULSE_HI    3
`define RFIA_RX1_PULSE_LO    2
`define RFIA_RX1_LEVEL_HI    1
`define RFIA_RX1_LEVEL_LO    0
`define RFIA_FIFO_DEPTH      32
`define RFIA_FIFO_HALF       16
`define RFIA_LABEL_BITS      8
`define RFIA_DATA_BITS       23
`define RFIA_WORD_BITS       32
`define RFIA_MAILBOXES       3
`define RFIA_LABEL_REV_BIT   6

`endif

// ===== rfia_pkg.sv
// rfia_pkg.sv: types shared by the event pin block
// assumes nothing
package rfia_pkg;
    typedef enum logic [1:0] {
        RFIA_PULSE_ANY = 2'b00,
        RFIA_PULSE_MB1 = 2'b01,
        RFIA_PULSE_MB2 = 2'b10,
        RFIA_PULSE_MB3 = 2'b11
    } rfia_pulse_sel_t;

    typedef enum logic [1:0] {
        RFIA_LEVEL_EMPTY    = 2'b00,
        RFIA_LEVEL_FULL     = 2'b01,
        RFIA_LEVEL_HALF     = 2'b10,
        RFIA_LEVEL_NOTEMPTY = 2'b11
    } rfia_level_sel_t;

    typedef enum logic [1:0] {
        RFIA_SPI_OPCODE = 2'b00,
        RFIA_SPI_DATA   = 2'b01,
        RFIA_SPI_IGNORE = 2'b10
    } rfia_spi_state_t;
endpackage

// ===== rfia_rx_event.sv
// rfia_rx_event.sv: one receiver's pulse and level pin from its selection bits
// assumes store strobes and fifo count synchronous to ref_clk
`timescale 1ns/1ps
`include "rfia_params.svh"
module rfia_rx_event #(
    parameter int DEPTH = `RFIA_FIFO_DEPTH,
    parameter int HALF  = `RFIA_FIFO_HALF,
    parameter int CW    = 6
) (
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    input  wire rfia_pkg::rfia_pulse_sel_t pulseSel,
    input  wire rfia_pkg::rfia_level_sel_t levelSel,
    input  wire logic                   fifoStore,
    input  wire logic [2:0]             mailboxStore,
    input  wire logic [CW-1:0]          fifoCount,
    output logic                        eventPulse,
    output logic                        eventLevel
);
    logic pulse_ff;
    logic level_ff;
    logic nxt_pulse;
    logic nxt_level;

    always_comb begin
        unique case (pulseSel)
            rfia_pkg::RFIA_PULSE_ANY: nxt_pulse = fifoStore | (|mailboxStore);
            rfia_pkg::RFIA_PULSE_MB1: nxt_pulse = mailboxStore[0];
            rfia_pkg::RFIA_PULSE_MB2: nxt_pulse = mailboxStore[1];
            rfia_pkg::RFIA_PULSE_MB3: nxt_pulse = mailboxStore[2];
        endcase
        unique case (levelSel)
            rfia_pkg::RFIA_LEVEL_EMPTY: nxt_level = (fifoCount == '0);
            rfia_pkg::RFIA_LEVEL_FULL:  nxt_level = (fifoCount == CW'(DEPTH));
            rfia_pkg::RFIA_LEVEL_HALF:  nxt_level = (fifoCount >= CW'(HALF));
            rfia_pkg::RFIA_LEVEL_NOTEMPTY: nxt_level = (fifoCount != '0);
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pulse_ff <= 1'b0;
            level_ff <= 1'b1;
        end else begin
            pulse_ff <= nxt_pulse;
            level_ff <= nxt_level;
        end
    end

    assign eventPulse = pulse_ff;
    assign eventLevel = level_ff;
endmodule

// ===== rfia_event_assign.sv
// rfia_event_assign.sv: assignment register on the spi byte stream, two receivers' pins,
// label bit order and mailbox word formatting
// assumes spi bytes already deserialised into strobes on ref_clk; csActive frames a transaction
`timescale 1ns/1ps
`include "rfia_params.svh"
module rfia_event_assign #(
    parameter int DEPTH = `RFIA_FIFO_DEPTH,
    parameter int CW    = 6
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        csActive,
    input  wire logic        rxByteValid,
    input  wire logic [7:0]  rxByte,
    input  wire logic        txByteTaken,
    output logic [7:0]       txByte,
    output logic             txByteValid,
    input  wire logic        rx1FifoStore,
    input  wire logic [2:0]  rx1MailboxStore,
    input  wire logic [CW-1:0] rx1FifoCount,
    input  wire logic        rx2FifoStore,
    input  wire logic [2:0]  rx2MailboxStore,
    input  wire logic [CW-1:0] rx2FifoCount,
    input  wire logic [7:0]  txControl,
    input  wire logic [31:0] txWordIn,
    output logic [31:0]      txWordOut,
    input  wire logic        rxLabelReverse,
    input  wire logic [31:0] rxWordIn,
    output logic [31:0]      rxWordOut,
    input  wire logic [7:0]  matchLabel,
    output logic [7:0]       matchCompare,
    input  wire logic [31:0] mailboxWord,
    output logic [23:0]      mailboxRead,
    output logic             rx1PulseOut,
    output logic             rx1LevelOut,
    output logic             rx2PulseOut,
    output logic             rx2LevelOut,
    output logic [7:0]       assignOut
);
    rfia_pkg::rfia_spi_state_t state_ff;
    rfia_pkg::rfia_spi_state_t nxt_state;
    logic [7:0]  assign_ff;
    logic [7:0]  nxt_assign;
    logic [7:0]  txb_ff;
    logic [7:0]  nxt_txb;
    logic        txv_ff;
    logic        nxt_txv;
    logic [31:0] txw_ff;
    logic [31:0] nxt_txw;
    logic [31:0] rxw_ff;
    logic [31:0] nxt_rxw;
    logic [7:0]  mc_ff;
    logic [23:0] mbr_ff;
    logic        writeSel_ff;
    logic        nxt_writeSel;
    logic        txLabelReverse;

    function automatic logic [7:0] rfia_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    // spi op-code decode for the assignment register
    always_comb begin
        nxt_state    = state_ff;
        nxt_assign   = assign_ff;
        nxt_txb      = txb_ff;
        nxt_txv      = txv_ff;
        nxt_writeSel = writeSel_ff;
        if (txByteTaken) begin
            nxt_txv = 1'b0;
        end
        if (!csActive) begin
            nxt_state    = rfia_pkg::RFIA_SPI_OPCODE;
            nxt_writeSel = 1'b0;
            nxt_txv      = 1'b0;
        end else if (rxByteValid) begin
            unique case (state_ff)
                rfia_pkg::RFIA_SPI_OPCODE: begin
                    if (rxByte == `RFIA_OP_ASSIGN_WR) begin
                        nxt_state    = rfia_pkg::RFIA_SPI_DATA;
                        nxt_writeSel = 1'b1;
                    end else if (rxByte == `RFIA_OP_ASSIGN_RD) begin
                        nxt_state = rfia_pkg::RFIA_SPI_IGNORE;
                        nxt_txb   = assign_ff;
                        nxt_txv   = 1'b1;
                    end else begin
                        nxt_state = rfia_pkg::RFIA_SPI_IGNORE;
                    end
                end
                rfia_pkg::RFIA_SPI_DATA: begin
                    if (writeSel_ff) begin
                        nxt_assign = rxByte;
                    end
                    nxt_writeSel = 1'b0;
                    nxt_state    = rfia_pkg::RFIA_SPI_IGNORE;
                end
                rfia_pkg::RFIA_SPI_IGNORE: begin
                    nxt_state = rfia_pkg::RFIA_SPI_IGNORE;
                end
                default: begin
                    nxt_state = rfia_pkg::RFIA_SPI_IGNORE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff    <= rfia_pkg::RFIA_SPI_OPCODE;
            assign_ff   <= `RFIA_ASSIGN_RESET;
            txb_ff      <= 8'h00;
            txv_ff      <= 1'b0;
            writeSel_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            assign_ff   <= nxt_assign;
            txb_ff      <= nxt_txb;
            txv_ff      <= nxt_txv;
            writeSel_ff <= nxt_writeSel;
        end
    end

    // label byte sits in bits 7:0 (first on the bus), data 30:8, parity 31
    assign txLabelReverse = txControl[`RFIA_LABEL_REV_BIT];

    always_comb begin
        nxt_txw = txWordIn;
        if (txLabelReverse) begin
            nxt_txw[`RFIA_LABEL_BITS-1:0] = rfia_rev8(txWordIn[7:0]);
        end
        nxt_rxw = rxWordIn;
        if (rxLabelReverse) begin
            nxt_rxw[`RFIA_LABEL_BITS-1:0] = rfia_rev8(rxWordIn[7:0]);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            txw_ff <= 32'h0000_0000;
            rxw_ff <= 32'h0000_0000;
            mc_ff  <= 8'h00;
            mbr_ff <= 24'h00_0000;
        end else begin
            txw_ff <= nxt_txw;
            rxw_ff <= nxt_rxw;
            mc_ff  <= matchLabel;
            mbr_ff <= mailboxWord[31:`RFIA_LABEL_BITS];
        end
    end

    rfia_rx_event #(.DEPTH(DEPTH), .HALF(`RFIA_FIFO_HALF), .CW(CW)) u_rx1 (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .pulseSel     (rfia_pkg::rfia_pulse_sel_t'(
                          assign_ff[`RFIA_RX1_PULSE_HI:`RFIA_RX1_PULSE_LO])),
        .levelSel     (rfia_pkg::rfia_level_sel_t'(
                          assign_ff[`RFIA_RX1_LEVEL_HI:`RFIA_RX1_LEVEL_LO])),
        .fifoStore    (rx1FifoStore),
        .mailboxStore (rx1MailboxStore),
        .fifoCount    (rx1FifoCount),
        .eventPulse   (rx1PulseOut),
        .eventLevel   (rx1LevelOut)
    );

    rfia_rx_event #(.DEPTH(DEPTH), .HALF(`RFIA_FIFO_HALF), .CW(CW)) u_rx2 (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .pulseSel     (rfia_pkg::rfia_pulse_sel_t'(
                          assign_ff[`RFIA_RX2_PULSE_HI:`RFIA_RX2_PULSE_LO])),
        .levelSel     (rfia_pkg::rfia_level_sel_t'(
                          assign_ff[`RFIA_RX2_LEVEL_HI:`RFIA_RX2_LEVEL_LO])),
        .fifoStore    (rx2FifoStore),
        .mailboxStore (rx2MailboxStore),
        .fifoCount    (rx2FifoCount),
        .eventPulse   (rx2PulseOut),
        .eventLevel   (rx2LevelOut)
    );

    assign txByte       = txb_ff;
    assign txByteValid  = txv_ff;
    assign txWordOut    = txw_ff;
    assign rxWordOut    = rxw_ff;
    assign matchCompare = mc_ff;
    assign mailboxRead  = mbr_ff;
    assign assignOut    = assign_ff;
endmodule

// ===== rfia_event_assign_chk.sv
// rfia_event_assign_chk.sv: port assertions for the event pin block
// assumes inputs held at zero during reset; bound into rfia_event_assign
`timescale 1ns/1ps
module rfia_event_assign_chk #(
    parameter int DEPTH = 32,
    parameter int CW    = 6
) (
    input wire logic          ref_clk, resetn, csActive, rxByteValid, txByteValid,
    input wire logic          rx1FifoStore, rx2FifoStore, rx1PulseOut, rx2PulseOut,
    input wire logic          rx1LevelOut, rx2LevelOut,
    input wire logic [2:0]    rx1MailboxStore, rx2MailboxStore,
    input wire logic [CW-1:0] rx1FifoCount, rx2FifoCount,
    input wire logic [7:0]    rxByte, txByte, txControl, assignOut,
    input wire logic [31:0]   txWordIn, txWordOut
);
    logic        hit1, hit2, lvl1, lvl2;
    logic [31:0] txExp;
    function automatic logic lvl(input logic [1:0] m, input logic [CW-1:0] c);
        return m == 0 ? c == 0 : m == 1 ? c == DEPTH : m == 2 ? c >= DEPTH / 2 : c != 0;
    endfunction
    always_comb begin
        hit1  = rx1MailboxStore[assignOut[3:2] - 2'd1];
        hit2  = rx2MailboxStore[assignOut[7:6] - 2'd1];
        lvl1  = lvl(assignOut[1:0], rx1FifoCount);
        lvl2  = lvl(assignOut[5:4], rx2FifoCount);
        txExp = txWordIn;
        for (int i = 0; i < 8; i++) txExp[i] = txControl[6] ? txWordIn[7 - i] : txWordIn[i];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    assign_write_a: assert property (csActive && !$past(csActive) && rxByteValid
        && rxByte == 8'h34 ##1 csActive && rxByteValid |=> assignOut == $past(rxByte))
        else $error("write lost");
    assign_read_a: assert property (csActive && !$past(csActive) && rxByteValid
        && rxByte == 8'hD0 |=> txByteValid && txByte == assignOut) else $error("read lost");
    rx1_any_a: assert property (assignOut[3:2] == 0
        && (rx1FifoStore || rx1MailboxStore != 0) |=> rx1PulseOut)
        else $error("rx1 pulse missed");
    rx1_mbox_a: assert property (assignOut[3:2] != 0 |=> rx1PulseOut == $past(hit1))
        else $error("rx1 mailbox pulse");
    rx1_level_a: assert property (rx1LevelOut == $past(lvl1))
        else $error("rx1 level");
    rx2_any_a: assert property (assignOut[7:6] == 0
        && (rx2FifoStore || rx2MailboxStore != 0) |=> rx2PulseOut)
        else $error("rx2 pulse missed");
    rx2_mbox_a: assert property (assignOut[7:6] != 0 |=> rx2PulseOut == $past(hit2))
        else $error("rx2 mailbox pulse");
    rx2_level_a: assert property (rx2LevelOut == $past(lvl2))
        else $error("rx2 level");
    tx_flip_a: assert property (txWordOut == $past(txExp))
        else $error("tx word");
endmodule
bind rfia_event_assign rfia_event_assign_chk #(.DEPTH(DEPTH), .CW(CW)) chk (.*);

// ===== rfia_host_model.sv
// rfia_host_model.sv: host side of the spi byte stream, one byte per cycle
// assumes read answers come on txByteValid within nine cycles of the op-code
`timescale 1ns/1ps
module rfia_host_model (
    input  wire logic       ref_clk,
    input  wire logic       txByteValid,
    input  wire logic [7:0] txByte,
    output logic            csActive    = 1'b0,
    output logic            rxByteValid = 1'b0,
    output logic [7:0]      rxByte      = 8'h00,
    output logic            txByteTaken = 1'b0
);
    task automatic send(input logic [7:0] b);
        @(posedge ref_clk);
        csActive    <= 1'b1;
        rxByteValid <= 1'b1;
        rxByte      <= b;
    endtask
    task automatic xfer(input logic [7:0] op, v, input bit xtra, output logic [7:0] rd,
                        output bit ok);
        send(op);
        if (op != 8'hD0) send(v);
        if (xtra) send(~v);
        @(posedge ref_clk);
        rxByteValid <= 1'b0;
        rxByte      <= ~rxByte;
        #1;
        for (int n = 0; n < 8 && op == 8'hD0 && txByteValid !== 1'b1; n++) @(posedge ref_clk) #1;
        ok = op != 8'hD0 || txByteValid === 1'b1;
        rd = txByte;
        @(posedge ref_clk);
        txByteTaken <= op == 8'hD0;
        @(posedge ref_clk);
        txByteTaken <= 1'b0;
        csActive    <= 1'b0;
    endtask
endmodule

// ===== tb_rx_flag_interrupt_assign.sv
// tb_rx_flag_interrupt_assign.sv: self-checking bench for the event pin block
// assumes rfia_host_model drives the spi byte stream
`timescale 1ns/1ps
module tb_rx_flag_interrupt_assign;
    logic        ref_clk = 0, resetn = 0, rxLabelReverse = 0, rx1FifoStore = 0, rx2FifoStore = 0;
    logic        csActive, rxByteValid, txByteTaken, txByteValid, ok;
    logic        rx1PulseOut, rx1LevelOut, rx2PulseOut, rx2LevelOut;
    logic [2:0]  rx1MailboxStore = '0, rx2MailboxStore = '0;
    logic [5:0]  rx1FifoCount = '0, rx2FifoCount = '0;
    logic [7:0]  txControl = '0, matchLabel = '0, rxByte, txByte, assignOut, matchCompare, rd;
    logic [31:0] txWordIn = '0, rxWordIn = '0, mailboxWord = '0, txWordOut, rxWordOut;
    logic [23:0] mailboxRead;
    int          numErrors = 0, cmpCount = 0;
    int          cnts[6] = '{0, 1, 15, 16, 31, 32};
    always #10 ref_clk = ~ref_clk;
    rfia_event_assign #(.DEPTH(32), .CW(6)) DUT (.*);
    rfia_host_model host (.*);
    function automatic logic lv(input int m, input int c);
        return m == 0 ? c == 0 : m == 1 ? c == 32 : m == 2 ? c >= 16 : c != 0;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic closeOut();
        $display("compares %0d mismatches %0d", cmpCount, numErrors);
        if (numErrors == 0 && cmpCount > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic op(input logic [7:0] c, v, input bit x);
        host.xfer(c, v, x, rd, ok);
        if (ok !== 1'b1) begin
            numErrors++;
            closeOut();
        end
    endtask
    task automatic pulse(input int s, input logic e1, input logic e2);
        @(posedge ref_clk);
        rx1FifoStore    <= s == 0;
        rx2FifoStore    <= s == 0;
        rx1MailboxStore <= 3'(8 >> (4 - s));
        rx2MailboxStore <= 3'(8 >> (4 - s));
        @(posedge ref_clk);
        {rx1FifoStore, rx2FifoStore, rx1MailboxStore, rx2MailboxStore} <= '0;
        #1;
        check(rx1PulseOut, e1);
        check(rx2PulseOut, e2);
        @(posedge ref_clk);
        #1;
        check({rx1PulseOut, rx2PulseOut}, 0);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        check({assignOut, rx1LevelOut, rx2LevelOut, rx1PulseOut, txByteValid}, 12'h00C);
        op(8'h34, 8'hA5, 0);
        op(8'hD0, 0, 0);
        check(rd, 8'hA5);
        op(8'h55, 8'h3C, 0);
        op(8'hD0, 0, 0);
        check(rd, 8'hA5);
        op(8'h34, 8'h96, 1);
        op(8'hD0, 0, 0);
        check(rd, 8'h96);
        @(posedge ref_clk);
        resetn <= 1'b0;
        @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        check({assignOut, rx1LevelOut, rx2LevelOut, rx1PulseOut, txByteValid}, 12'h00C);
        $display("register test done");
        for (int m = 0; m < 4; m++) begin
            op(8'h34, 8'(m * 8'h04 + (3 - m) * 8'h40), 0);
            for (int s = 0; s < 4; s++) pulse(s, m == 0 || s == m, m == 3 || s == 3 - m);
        end
        $display("pulse test done");
        for (int l = 0; l < 4; l++) begin
            op(8'h34, 8'(l + (3 - l) * 8'h10), 0);
            foreach (cnts[i]) begin
                @(posedge ref_clk);
                rx1FifoCount <= 6'(cnts[i]);
                rx2FifoCount <= 6'(32 - cnts[i]);
                @(posedge ref_clk);
                #1;
                check(rx1LevelOut, lv(l, cnts[i]));
                check(rx2LevelOut, lv(3 - l, 32 - cnts[i]));
            end
        end
        $display("level test done");
        for (int f = 0; f < 2; f++) begin
            @(posedge ref_clk);
            txControl      <= f ? 8'h40 : 8'hBF;
            rxLabelReverse <= f[0];
            matchLabel     <= 8'h0F;
            txWordIn       <= 32'h1234_5601;
            rxWordIn       <= 32'h89AB_CDE0;
            mailboxWord    <= 32'h1234_5601;
            @(posedge ref_clk);
            #1;
            check(txWordOut, f ? 32'h1234_5680 : 32'h1234_5601);
            check(rxWordOut, f ? 32'h89AB_CD07 : 32'h89AB_CDE0);
            check(matchCompare, 8'h0F);
            check(mailboxRead, 24'h12_3456);
        end
        $display("word test done");
        closeOut();
    end
    initial begin
        #1_000_000;
        numErrors++;
        closeOut();
    end
endmodule
